// >>> core/trs_pkg.sv
// Purpose: Shared constants and types for the trip restart and fire input block
// Assumes: 100 MHz system clock, 32-bit Avalon-MM register bus
// Notes: Register fields are laid out by the packed structs below
package trs_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICKS_PER_S = 1_000_000_000 / TICK_NS;
    localparam int RETRY_S = 20;
    localparam int RETRY_TICKS = RETRY_S * TICKS_PER_S;
    localparam logic [2:0] MAX_ATTEMPTS = 3'h5;

    // Register byte addresses
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_CMD = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;

    // Command bit positions
    localparam int CMD_MAN_RST = 0;
    localparam int CMD_FIRE_CLR = 1;

    // Input function codes that route input 3 to fire mode
    localparam logic [4:0] FIRE_FUNC_LO = 5'h0f;
    localparam logic [4:0] FIRE_FUNC_HI = 5'h12;

    // Control modes that mean keypad control
    localparam logic [3:0] MODE_KEYPAD_FWD = 4'h1;
    localparam logic [3:0] MODE_KEYPAD_REV = 4'h2;

    // Start selection codes
    localparam logic [2:0] SEL_MIN_KEY = 3'h0;
    localparam logic [2:0] SEL_PREV_KEY = 3'h1;
    localparam logic [2:0] SEL_MIN_TERM = 3'h2;
    localparam logic [2:0] SEL_PREV_TERM = 3'h3;
    localparam logic [2:0] SEL_CUR_KEY = 3'h4;
    localparam logic [2:0] SEL_CUR_KEY_B = 3'h5;

    // Start speed codes
    localparam logic [1:0] SPD_MIN = 2'h0;
    localparam logic [1:0] SPD_PREV = 2'h1;
    localparam logic [1:0] SPD_CUR = 2'h2;

    // Configuration register
    typedef struct packed {
        logic [10:0] rsvd_a;
        logic [4:0] in_func;
        logic [3:0] ctrl_mode;
        logic rsvd_b;
        logic [2:0] start_sel;
        logic [1:0] rsvd_c;
        logic fire_latch;
        logic fire_pol;
        logic rsvd_d;
        logic [2:0] attempts;
    } trs_cfg_t;

    // Status register
    typedef struct packed {
        logic [24:0] rsvd;
        logic run;
        logic fire;
        logic locked;
        logic retry_pend;
        logic [2:0] used;
    } trs_stat_t;

    localparam trs_cfg_t CFG_RST = 32'h0000_0000;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TRY, ST_LOCK} trs_state_t;
endpackage : trs_pkg

// >>> core/trs_top.sv
// Purpose: Auto trip restart sequencer, fire input conditioning, keypad start selection
// Assumes: Trip and start-ok events come from drive logic on clk; keys and fire pin are async
// Notes: One wait state on every bus access
// Summary of operation
// R1: After a trip, auto reset and restart, up to 5 attempts, 20 s apart.
// R2: If last attempt fails, stay tripped and latched until manual reset.
// R3: Attempt count survives fault resets; only power-up reset clears it.
// R4: Fire polarity 0 means active on open contact, 1 active on closed.
// R5: Latch 0 follows active level; latch 1 holds after a momentary pulse.
// R6: Both fire behaviours honour the configured polarity.
// R7: Start selection only acts in keypad control mode.
// R8: Keypad-start selections accept start and stop only from keypad keys.
// R9: Terminal-start selections also allow starting from the terminal input.
// R10: Selection 0..3 decode min/previous speed with keypad/terminal start.
// R11: Fire override only enabled when input function is 15 to 18.
// R12: Override suppresses soft trips; hard trips still trip and auto restart.
// R13: Retry interval timed by tick-driven counter, restarted each new attempt.
//
// The address map and the Avalon-MM register port are this design's own decisions.
module trs_top
    import trs_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC,
    parameter int RETRY_TICKS_P = RETRY_TICKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Drive logic events
    input wire logic trip_evt,
    input wire logic trip_hard,
    input wire logic start_ok,
    // Pins
    input wire logic fire_pin,
    input wire logic key_start,
    input wire logic key_stop,
    input wire logic term_start,
    // Drive controls
    output logic restart_pulse,
    output logic locked,
    output logic fire_active,
    output logic run_cmd,
    output logic [1:0] speed_sel
);
    localparam int TW = $clog2(TICK_CYC_P + 1);
    localparam int RW = $clog2(RETRY_TICKS_P + 1);

    // Rising edge of a synchronised level
    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rise

    // Register state
    trs_cfg_t cfg_ff, nxt_cfg;
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    logic man_rst, fire_clr;
    trs_stat_t stat;

    // Pin synchronisers, stage 3 feeds edge detection
    logic [3:0] s1_ff, s2_ff, s3_ff;
    logic fire_lvl, kst, ksp, tst, kst_e, ksp_e, tst_e;

    // Sequencer state
    trs_state_t st_ff, nxt_st;
    logic [2:0] used_ff, nxt_used;
    logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
    logic [RW-1:0] retry_cnt_ff, nxt_retry_cnt;
    logic pulse_ff, nxt_pulse;
    logic tick, trip_eff, can_retry;
    logic [2:0] lim;

    // Fire and start state
    logic fire_ff, nxt_fire;
    logic run_ff, nxt_run;
    logic [1:0] spd_ff, nxt_spd;
    logic fire_en, fire_req, keypad, term_ok;

    // Bus handshake: one wait state, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign avs_readdata = rdata_ff;
    assign man_rst = avs_write & ack_ff & (avs_address == ADDR_CMD) & avs_writedata[CMD_MAN_RST];
    assign fire_clr = avs_write & ack_ff & (avs_address == ADDR_CMD) & avs_writedata[CMD_FIRE_CLR];

    // Status view of internal state
    always_comb begin
        stat = '0;
        stat.run = run_ff;
        stat.fire = fire_ff;
        stat.locked = (st_ff == ST_LOCK);
        stat.retry_pend = (st_ff == ST_WAIT);
        stat.used = used_ff;
    end

    // Register file next values
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_ack = (avs_read | avs_write) & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (avs_write && ack_ff && avs_address == ADDR_CFG) begin
            nxt_cfg = avs_writedata;
            nxt_cfg.rsvd_a = '0;
            nxt_cfg.rsvd_b = 1'b0;
            nxt_cfg.rsvd_c = '0;
            nxt_cfg.rsvd_d = 1'b0;
        end
        if (avs_read && !ack_ff) begin
            case (avs_address)
                ADDR_CFG: nxt_rdata = cfg_ff;
                ADDR_STAT: nxt_rdata = stat;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= CFG_RST;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            cfg_ff <= nxt_cfg;
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // Two-flop synchronisers for pins, third stage for edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= 4'h0;
            s2_ff <= 4'h0;
            s3_ff <= 4'h0;
        end else begin
            s1_ff <= {term_start, key_stop, key_start, fire_pin};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // R4 polarity select: pin high means contact closed
    // R6 shared by both behaviours
    assign fire_lvl = cfg_ff.fire_pol ? s2_ff[0] : ~s2_ff[0];
    assign kst = s2_ff[1];
    assign ksp = s2_ff[2];
    assign tst = s2_ff[3];
    assign kst_e = rise(kst, s3_ff[1]);
    assign ksp_e = rise(ksp, s3_ff[2]);
    assign tst_e = rise(tst, s3_ff[3]);

    // R11 fire enable decode
    assign fire_en = (cfg_ff.in_func >= FIRE_FUNC_LO) && (cfg_ff.in_func <= FIRE_FUNC_HI);
    assign fire_req = fire_en & fire_lvl;
    assign keypad = (cfg_ff.ctrl_mode == MODE_KEYPAD_FWD) || (cfg_ff.ctrl_mode == MODE_KEYPAD_REV);
    // R9 terminal start allowed only for terminal selections
    assign term_ok = keypad &&
        (cfg_ff.start_sel == SEL_MIN_TERM || cfg_ff.start_sel == SEL_PREV_TERM);

    // Fire override and run command next values
    always_comb begin
        nxt_fire = fire_ff;
        nxt_run = run_ff;
        nxt_spd = spd_ff;
        // R5 maintained or momentary override
        if (!fire_en) begin
            nxt_fire = 1'b0;
        end else if (!cfg_ff.fire_latch) begin
            nxt_fire = fire_lvl;
        end else if (fire_lvl) begin
            nxt_fire = 1'b1; // Set wins over clear
        end else if (fire_clr) begin
            nxt_fire = 1'b0;
        end
        // R7 speed kept outside keypad
        // R10 start speed decode
        if (keypad) begin
            case (cfg_ff.start_sel)
                SEL_MIN_KEY, SEL_MIN_TERM: nxt_spd = SPD_MIN;
                SEL_PREV_KEY, SEL_PREV_TERM: nxt_spd = SPD_PREV;
                SEL_CUR_KEY, SEL_CUR_KEY_B: nxt_spd = SPD_CUR;
                default: nxt_spd = SPD_MIN;
            endcase
        end
        // R7 keypad selection only in keypad mode
        // R8 keys count in keypad mode; terminal only when permitted
        if (!keypad) begin
            nxt_run = tst;
        end else if (ksp_e) begin
            nxt_run = 1'b0;
        end else if (kst_e || (term_ok && tst_e)) begin
            nxt_run = 1'b1;
        end
        if (trip_eff) begin
            nxt_run = 1'b0;
        end else if (pulse_ff) begin
            nxt_run = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fire_ff <= 1'b0;
            run_ff <= 1'b0;
            spd_ff <= SPD_MIN;
        end else begin
            fire_ff <= nxt_fire;
            run_ff <= nxt_run;
            spd_ff <= nxt_spd;
        end
    end

    // R12 soft trips suppressed under override
    assign trip_eff = trip_evt & (trip_hard | ~fire_ff);
    assign lim = (cfg_ff.attempts > MAX_ATTEMPTS) ? MAX_ATTEMPTS : cfg_ff.attempts;
    assign can_retry = fire_ff | (used_ff < lim);
    assign tick = (tick_cnt_ff == TW'(TICK_CYC_P - 1));

    // Restart sequencer next values
    always_comb begin
        nxt_st = st_ff;
        nxt_used = used_ff;
        nxt_pulse = 1'b0;
        nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
        nxt_retry_cnt = retry_cnt_ff;
        case (st_ff)
            ST_IDLE, ST_TRY: begin
                if (trip_eff) begin
                    // R2 no attempts left locks the fault
                    nxt_st = can_retry ? ST_WAIT : ST_LOCK;
                    // R13 interval restarts with each trip
                    nxt_retry_cnt = '0;
                    nxt_tick_cnt = '0;
                end else if (st_ff == ST_TRY && start_ok) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (tick) begin
                    nxt_retry_cnt = retry_cnt_ff + 1'b1;
                end
                // R1 reset and retry after interval
                if (tick && retry_cnt_ff == RW'(RETRY_TICKS_P - 1)) begin
                    nxt_st = ST_TRY;
                    nxt_pulse = 1'b1;
                    // R3 count saturates, never cleared here
                    if (used_ff < MAX_ATTEMPTS) begin
                        nxt_used = used_ff + 1'b1;
                    end
                end
            end
            ST_LOCK: begin
                if (man_rst) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            used_ff <= 3'h0;
            tick_cnt_ff <= '0;
            retry_cnt_ff <= '0;
            pulse_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            used_ff <= nxt_used;
            tick_cnt_ff <= nxt_tick_cnt;
            retry_cnt_ff <= nxt_retry_cnt;
            pulse_ff <= nxt_pulse;
        end
    end

    // Outputs
    assign restart_pulse = pulse_ff;
    assign locked = (st_ff == ST_LOCK);
    assign fire_active = fire_ff;
    assign run_cmd = run_ff;
    assign speed_sel = spd_ff;

    // Checks
    AST_RETRY_SPACING: assert property (@(posedge clk) disable iff (!rst_n) // R1
        nxt_pulse |-> (st_ff == ST_WAIT) && retry_cnt_ff == RW'(RETRY_TICKS_P - 1) && tick)
        else $error("restart issued before interval elapsed");
    AST_MAX_COUNT: assert property (@(posedge clk) disable iff (!rst_n) // R1
        used_ff <= MAX_ATTEMPTS)
        else $error("attempt count above limit");
    AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (st_ff == ST_LOCK) && !man_rst |=> st_ff == ST_LOCK)
        else $error("locked fault left without manual reset");
    AST_LOCK_ENTRY: assert property (@(posedge clk) disable iff (!rst_n) // R2
        trip_eff && !can_retry && st_ff != ST_WAIT && st_ff != ST_LOCK |=> locked)
        else $error("exhausted attempts did not lock");
    AST_COUNT_KEPT: assert property (@(posedge clk) disable iff (!rst_n) // R3
        used_ff >= $past(used_ff))
        else $error("attempt count decreased without power reset");
    AST_FIRE_POL: assert property (@(posedge clk) disable iff (!rst_n) // R4
        fire_en && !cfg_ff.fire_latch
        |=> fire_ff == ($past(cfg_ff.fire_pol) ? $past(s2_ff[0]) : !$past(s2_ff[0])))
        else $error("maintained fire level wrong for polarity");
    AST_FIRE_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // R5
        fire_ff && fire_en && cfg_ff.fire_latch && !fire_clr ##1 fire_en && cfg_ff.fire_latch
        |-> fire_ff)
        else $error("momentary fire override dropped");
    AST_FIRE_DISABLED: assert property (@(posedge clk) disable iff (!rst_n) // R11
        !fire_en |=> !fire_ff)
        else $error("fire override active while input not assigned");
    AST_NOT_KEYPAD: assert property (@(posedge clk) disable iff (!rst_n) // R7
        !keypad && !trip_eff && !pulse_ff |=> run_ff == $past(tst))
        else $error("start selection acted outside keypad mode");
    AST_KEY_ONLY: assert property (@(posedge clk) disable iff (!rst_n) // R8
        keypad && !term_ok && !run_ff && !kst_e && !pulse_ff |=> !run_ff)
        else $error("run started from terminal in keypad-start mode");
    AST_SOFT_SUPPRESS: assert property (@(posedge clk) disable iff (!rst_n) // R12
        trip_evt && !trip_hard && fire_ff && st_ff == ST_IDLE && !start_ok |=> st_ff == ST_IDLE)
        else $error("soft trip not suppressed under override");
    AST_TIMER_RESTART: assert property (@(posedge clk) disable iff (!rst_n) // R13
        trip_eff && st_ff != ST_WAIT && st_ff != ST_LOCK |=> retry_cnt_ff == '0)
        else $error("retry interval not restarted");
endmodule : trs_top

// >>> sim/trs_field.sv
// Purpose: Field side model: fire contact, keypad keys and terminal switch
// Assumes: Bench asks for alarm and key presses as levels just after clk rises
// Notes: A normally closed contact opens on alarm, a normally open one closes
module trs_field (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic alarm,
    input wire logic nc_wire,
    input wire logic [2:0] press,
    // Pins toward the block, high means contact closed
    output logic fire_pin,
    output logic key_start,
    output logic key_stop,
    output logic term_start
);
    timeunit 1ns;
    timeprecision 1ps;

    // Contacts follow the requests one clock later
    always @(posedge clk) begin
        fire_pin <= alarm ^ nc_wire;
        key_start <= press[0];
        key_stop <= press[1];
        term_start <= press[2];
    end
endmodule : trs_field

// >>> sim/trs_top_bench.sv
// Purpose: Self-checking bench for the trip restart and fire input block
// Assumes: Short tick and interval parameters keep the run brief
// Notes: Fixed seed makes the random configurations repeatable
module trs_top_bench
    import trs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TK = 4;
    localparam int RT = 5;
    localparam int IVL = TK * RT;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic trip_evt = 1'b0;
    logic trip_hard = 1'b0;
    logic start_ok = 1'b0;
    logic alarm = 1'b0;
    logic nc_wire = 1'b0;
    logic [2:0] press = 3'h0;
    logic fire_pin, key_start, key_stop, term_start;
    logic restart_pulse, locked, fire_active, run_cmd;
    logic [1:0] speed_sel;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'haa56;
    logic [31:0] rd;
    logic [3:0] n_addr [2] = '{ADDR_CMD, 4'hc};
    logic [4:0] n_func [2] = '{FIRE_FUNC_LO - 5'h1, FIRE_FUNC_HI + 5'h1};

    trs_top #(.TICK_CYC_P(TK), .RETRY_TICKS_P(RT)) trs_top_inst (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trip_evt(trip_evt), .trip_hard(trip_hard),
        .start_ok(start_ok), .fire_pin(fire_pin), .key_start(key_start), .key_stop(key_stop),
        .term_start(term_start), .restart_pulse(restart_pulse), .locked(locked),
        .fire_active(fire_active), .run_cmd(run_cmd), .speed_sel(speed_sel));

    trs_field trs_field_inst (
        .clk(clk), .alarm(alarm), .nc_wire(nc_wire), .press(press), .fire_pin(fire_pin),
        .key_start(key_start), .key_stop(key_stop), .term_start(term_start));

    // Clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask : ticks

    // One bus access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        if (k >= 50) begin
            check(1'b0, 1'b1, "bus wait ran out");
            complete_run();
        end
    endtask : bus

    task automatic trip(input logic hard);
        trip_hard <= hard;
        trip_evt <= 1'b1;
        @(posedge clk);
        trip_evt <= 1'b0;
    endtask : trip

    task automatic ok_pulse();
        start_ok <= 1'b1;
        @(posedge clk);
        start_ok <= 1'b0;
    endtask : ok_pulse

    // Cycles from t0 to a restart pulse, 0 if none within lim
    task automatic wait_rs(input longint t0, input int lim, output int n);
        int k;
        k = 0;
        n = 0;
        do begin
            @(negedge clk);
            k++;
        end while (restart_pulse !== 1'b1 && k < lim);
        if (restart_pulse === 1'b1) n = int'(($time - t0 + 5) / 10);
        @(posedge clk);
    endtask : wait_rs

    task automatic push(input int b);
        press[b] <= 1'b1;
        ticks(3);
        press[b] <= 1'b0;
        ticks(8);
    endtask : push

    function automatic logic [31:0] mk_cfg(input logic [2:0] att, input logic pol,
        input logic lat, input logic [2:0] sel, input logic [3:0] md, input logic [4:0] fn);
        return trs_cfg_t'{11'h0, fn, md, 1'b0, sel, 2'h0, lat, pol, 1'b0, att};
    endfunction : mk_cfg

    function automatic int exp_lim(input logic [2:0] a);
        return (a > MAX_ATTEMPTS) ? int'(MAX_ATTEMPTS) : int'(a);
    endfunction : exp_lim

    function automatic logic [1:0] exp_spd(input int s);
        if (s == 1 || s == 3) return SPD_PREV;
        if (s == 4 || s == 5) return SPD_CUR;
        return SPD_MIN;
    endfunction : exp_spd

    // Main sequence
    initial begin
        int att;
        int n;
        longint t0;
        logic [3:0] md;
        ticks(2);
        rst_n <= 1'b1;
        @(posedge clk);
        // Status reset value, field masks, refused places
        bus(1'b0, ADDR_STAT, 32'h0);
        check(rd, 32'h0, "stat reset");
        bus(1'b1, ADDR_CFG, 32'hffff_ffff);
        bus(1'b0, ADDR_CFG, 32'h0);
        check(rd, mk_cfg(3'h7, 1'b1, 1'b1, 3'h7, 4'hf, 5'h1f), "cfg fields");
        foreach (n_addr[i]) begin
            bus(1'b1, n_addr[i], 32'hffff_ffff);
            bus(1'b0, n_addr[i], 32'h0);
            check(rd, 32'h0, "refused place");
        end
        $display("test done: registers");
        // Attempts up to the limit, then lock; count kept until power cycle
        for (int r = 0; r < 2; r++) begin
            att = (r == 0) ? 7 : ($random(seed) & 7);
            bus(1'b1, ADDR_CFG, mk_cfg(att[2:0], 1'b0, 1'b0, 3'h0, 4'h0, 5'h0));
            for (int i = 0; i < exp_lim(att[2:0]); i++) begin
                trip(1'b0);
                t0 = $time;
                bus(1'b0, ADDR_STAT, 32'h0);
                check(rd[3], 1'b1, "retry pending");
                wait_rs(t0, 3 * IVL, n);
                check(n >= IVL - 1 && n <= IVL + 2, 1'b1, "retry interval");
                if (n == 0) complete_run();
                ok_pulse();
                bus(1'b0, ADDR_STAT, 32'h0);
                check(rd[2:0], i + 1, "attempts used");
            end
            trip(1'b0);
            wait_rs($time, 3 * IVL, n);
            check(n, 0, "no retry past limit");
            check(locked, 1'b1, "fault latched");
            bus(1'b1, ADDR_CMD, 32'h1);
            check(locked, 1'b0, "manual reset");
            bus(1'b0, ADDR_STAT, 32'h0);
            check(rd[2:0], exp_lim(att[2:0]), "count kept");
            trip(1'b0);
            ticks(2);
            check(locked, 1'b1, "no attempts left");
            rst_n <= 1'b0;
            ticks(2);
            rst_n <= 1'b1;
            @(posedge clk);
            bus(1'b0, ADDR_STAT, 32'h0);
            check(rd[2:0], 3'h0, "count cleared");
        end
        $display("test done: restart");
        // Fire override for each polarity and latch mode
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, ADDR_CFG, 32'h0);
            nc_wire <= !m[0];
            ticks(6);
            bus(1'b1, ADDR_CFG, mk_cfg(3'h1, m[0], m[1], 3'h0, 4'h0,
                FIRE_FUNC_LO + 5'($random(seed) & 3)));
            check(fire_active, 1'b0, "fire idle");
            alarm <= 1'b1;
            ticks(8);
            check(fire_active, 1'b1, "fire on");
            trip(1'b0);
            wait_rs($time, 3 * IVL, n);
            check(n, 0, "soft trip suppressed");
            trip(1'b1);
            wait_rs($time, 3 * IVL, n);
            check(n >= IVL - 1 && n <= IVL + 2, 1'b1, "hard trip retried");
            if (n == 0) complete_run();
            ok_pulse();
            alarm <= 1'b0;
            ticks(8);
            check(fire_active, m[1], "fire after release");
            bus(1'b1, ADDR_CMD, 32'h2);
            check(fire_active, 1'b0, "fire cleared");
        end
        // Input functions next to the fire codes
        nc_wire <= 1'b0;
        foreach (n_func[i]) begin
            bus(1'b1, ADDR_CFG, mk_cfg(3'h1, 1'b1, 1'b0, 3'h0, 4'h0, n_func[i]));
            alarm <= 1'b1;
            ticks(8);
            check(fire_active, 1'b0, "fire disabled");
            alarm <= 1'b0;
        end
        $display("test done: fire");
        // Keypad start selections
        for (int s = 0; s < 6; s++) begin
            md = s[0] ? MODE_KEYPAD_REV : MODE_KEYPAD_FWD;
            bus(1'b1, ADDR_CFG, mk_cfg(3'h0, 1'b0, 1'b0, s[2:0], md, 5'h0));
            push(2);
            check(run_cmd, s == 2 || s == 3, "terminal start");
            push(1);
            check(run_cmd, 1'b0, "stop key");
            push(0);
            check(run_cmd, 1'b1, "start key");
            check(speed_sel, exp_spd(s), "start speed");
            push(1);
        end
        // Other control modes ignore the selection
        for (int k = 0; k < 2; k++) begin
            md = k ? 4'(3 + ($random(seed) & 11)) : 4'h0;
            bus(1'b1, ADDR_CFG, mk_cfg(3'h0, 1'b0, 1'b0, 3'h1, md, 5'h0));
            push(0);
            check(run_cmd, 1'b0, "key ignored");
            check(speed_sel, SPD_CUR, "speed held");
            press[2] <= 1'b1;
            ticks(8);
            check(run_cmd, 1'b1, "terminal level");
            press[2] <= 1'b0;
            ticks(8);
        end
        $display("test done: start select");
        complete_run();
    end
endmodule : trs_top_bench
